// [src/psr_defines.svh]
`ifndef PSR_DEFINES_SVH
`define PSR_DEFINES_SVH
`define PSR_OFF_CTRL     8'h00
`define PSR_OFF_DDR      8'h04
`define PSR_OFF_PORT     8'h08
`define PSR_OFF_STATUS   8'h0c
`define PSR_CTRL_MODE_LO 0
`define PSR_CTRL_MODE_HI 2
`define PSR_CTRL_ADRC    3
`define PSR_DDR_CS       24
`define PSR_CTRL_RST     32'h0000_0001
`define PSR_DDR_RST      25'h000_0000
`define PSR_PORT_RST     24'h00_0000
`define PSR_ADDR_LOW_HI  19
`define PSR_ADDR_A20     20
`define PSR_ADDR_UP_LO   21
`endif

// [src/psr_pkg.sv]
package psr_pkg;
  typedef enum logic [2:0] {
    PSR_IDLE, PSR_T1, PSR_T2, PSR_TW, PSR_T3
  } psr_bus_state_t;

  typedef struct packed {
    psr_bus_state_t bus_state;
    logic [23:0]    acc_addr;
    logic           acc_wr;
    logic           acc_two;
    logic [7:0]     acc_wdata;
    logic [7:0]     acc_rdata;
    logic           acc_done;
    logic           held;
    logic [23:0]    addr;
    logic [23:0]    addr_oe;
    logic [2:0]     mode;
    logic           adrc;
    logic [24:0]    ddr;
    logic [23:0]    port_out;
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
    logic           clk_out;
    logic           clk_oe;
    logic           rst_out_oe;
  } psr_core_t;

  typedef struct packed {
    logic       as_n;
    logic       rd_n;
    logic       wr_n;
    logic       strobe_oe;
    logic [7:0] data;
    logic       data_oe;
    logic       cs_oe;
  } psr_pin_t;
endpackage

// [src/psr_top.sv]
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "psr_defines.svh"
module psr_top (
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_chip_init_n,
  input  wire logic        i_hw_standby,
  input  wire logic        i_sw_standby,
  input  wire logic        i_wdt_reset,
  input  wire logic        i_acc_start,
  input  wire logic        i_acc_write,
  input  wire logic        i_acc_two_state,
  input  wire logic [23:0] i_acc_addr,
  input  wire logic [7:0]  i_acc_wdata,
  input  wire logic        i_wait_n,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  output logic             o_acc_done,
  output logic [7:0]       o_acc_rdata,
  output logic [23:0]      o_addr,
  output logic [23:0]      o_addr_oe,
  output logic [7:0]       o_data,
  output logic             o_data_oe,
  output logic             o_addr_strobe_n,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic             o_strobe_oe,
  output logic             o_cs,
  output logic             o_cs_oe,
  output logic             o_reset_out_n,
  output logic             o_reset_out_oe,
  output logic             o_clk_out,
  output logic             o_clk_oe
);
  psr_pkg::psr_core_t st;
  psr_pkg::psr_core_t next_st;
  psr_pkg::psr_pin_t  pn;
  psr_pkg::psr_pin_t  next_pn;
  logic               init_low;
  logic               init_hold;
  logic               pin_rst;
  logic               expanded;
  logic               busy;
  logic               reading;
  logic               ready_mode;
  logic               apb_wr;
  logic [31:0]        rd_word;
  logic               hit;
  logic               fn_addr;
  logic               port_keep;

  // Pin drivers reset without a clock; the address bus is left out because
  // it must be able to hold its value through the last bus state (T3, or T2 of a two-state access).
  // immediate pin reset
  assign pin_rst = i_rst | ~i_chip_init_n;

  // Sampling on the falling edge leaves half a state between the sample and
  // the rising edge at which the address bus is forced low.
  // falling edge sample
  always_ff @(negedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      init_low  <= 1'b0;
      init_hold <= 1'b0;
    end else begin
      init_low <= ~i_chip_init_n;
      if (!init_low) begin
        init_hold <= (st.bus_state == psr_pkg::PSR_T3) |
                     ((st.bus_state == psr_pkg::PSR_T2) & st.acc_two);
      end
    end
  end

  always_comb begin
    next_st = st;
    next_pn = pn;
    expanded = (st.mode == 3'h1) | (st.mode == 3'h3) | (st.mode == 3'h5);
    apb_wr = i_psel & i_penable & st.pready & i_pwrite;
    next_st.acc_done = 1'b0;
    next_st.clk_out = ~st.clk_out;

    // External access sequencer; a sampled reset aborts it.
    // A start outside the idle state is ignored rather than queued.
    case (st.bus_state)
      psr_pkg::PSR_IDLE: begin
        if (i_acc_start & expanded & ~init_low &
            ~i_sw_standby & ~i_hw_standby) begin
          next_st.bus_state = psr_pkg::PSR_T1;
          next_st.acc_addr  = i_acc_addr;
          next_st.acc_wr    = i_acc_write;
          next_st.acc_two   = i_acc_two_state;
          next_st.acc_wdata = i_acc_wdata;
        end
      end
      psr_pkg::PSR_T1: next_st.bus_state = psr_pkg::PSR_T2;
      psr_pkg::PSR_T2: begin
        if (st.acc_two) begin
          next_st.bus_state = psr_pkg::PSR_IDLE;
          next_st.acc_done  = 1'b1;
          next_st.acc_rdata = st.acc_wr ? st.acc_rdata : i_data;
        end else if (!i_wait_n) begin
          next_st.bus_state = psr_pkg::PSR_TW;
        end else begin
          next_st.bus_state = psr_pkg::PSR_T3;
        end
      end
      psr_pkg::PSR_TW: begin
        if (i_wait_n) begin
          next_st.bus_state = psr_pkg::PSR_T3;
        end
      end
      psr_pkg::PSR_T3: begin
        next_st.bus_state = psr_pkg::PSR_IDLE;
        next_st.acc_done  = 1'b1;
        next_st.acc_rdata = st.acc_wr ? st.acc_rdata : i_data;
      end
      default: next_st.bus_state = psr_pkg::PSR_IDLE;
    endcase
    if (init_low) begin
      next_st.bus_state = psr_pkg::PSR_IDLE;
      next_st.acc_done  = 1'b0;
    end

    // Strobes follow the state being entered so they leave a flip-flop.
    busy = next_st.bus_state != psr_pkg::PSR_IDLE;
    reading = busy & ~next_st.acc_wr;
    next_pn.as_n = ~busy;
    next_pn.rd_n = ~reading;
    next_pn.wr_n = ~(busy & next_st.acc_wr &
                   (next_st.bus_state != psr_pkg::PSR_T1));
    next_pn.data = next_st.acc_wdata;
    next_pn.data_oe = ~next_pn.wr_n & ~i_hw_standby;
    next_pn.strobe_oe = expanded & ~i_hw_standby & ~i_sw_standby;
    // select pin drives high
    // The select pin's level equals its enable, so it is never driven low.
    if (i_hw_standby) begin
      next_pn.cs_oe = 1'b0;
    end else if (expanded | ~i_sw_standby) begin
      next_pn.cs_oe = st.ddr[`PSR_DDR_CS];
    end else begin
      next_pn.cs_oe = pn.cs_oe;
    end

    // Address pins: bus function, port function, reset and standby.
    // Limitation: pins not driven low in reset (all of them outside modes one and three) float one edge after the
    // reset sample, not at once; strobes, data and select act without a clock.
    ready_mode = (st.mode == 3'h1) | (st.mode == 3'h3);
    fn_addr = 1'b0;
    port_keep = 1'b0;
    for (int i = 0; i < 24; i++) begin
      fn_addr = 1'b0;
      if (i <= `PSR_ADDR_LOW_HI) begin
        fn_addr = ready_mode | ((st.mode == 3'h5) & st.ddr[i]);
      end else if (i == `PSR_ADDR_A20) begin
        fn_addr = st.mode == 3'h3;
      end else begin
        fn_addr = (st.mode == 3'h3) & ~st.adrc;
      end
      port_keep = ~fn_addr & ~(i <= `PSR_ADDR_LOW_HI &&
                               st.mode == 3'h5);
      if (i_hw_standby) begin
        next_st.addr_oe[i] = 1'b0;
      end else if (init_low) begin
        if (!(init_hold & ~st.held)) begin
          next_st.addr[i] = 1'b0;
        end
        next_st.addr_oe[i] = ready_mode & (i <= `PSR_ADDR_A20) &
                             ((i < `PSR_ADDR_A20) | (st.mode == 3'h3));
      end else if (i_sw_standby) begin
        next_st.addr_oe[i] = port_keep ? st.addr_oe[i] : 1'b0;
      end else if (fn_addr) begin
        next_st.addr[i]    = next_st.acc_addr[i];
        next_st.addr_oe[i] = 1'b1;
      end else begin
        next_st.addr[i]    = st.port_out[i];
        next_st.addr_oe[i] = port_keep & st.ddr[i];
      end
    end
    // Only one extra state of hold is given; held records that it was used.
    // hold one state
    next_st.held = init_low & (st.held | init_hold);

    next_st.rst_out_oe = i_wdt_reset & ~i_hw_standby;
    // The clock output keeps running in reset and in software standby.
    next_st.clk_oe = ~i_hw_standby;

    // APB slave: access phase takes two cycles, answer leaves a flip-flop.
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    if (i_paddr == `PSR_OFF_CTRL) begin
      rd_word[`PSR_CTRL_MODE_HI:`PSR_CTRL_MODE_LO] = st.mode;
      rd_word[`PSR_CTRL_ADRC] = st.adrc;
    end else if (i_paddr == `PSR_OFF_DDR) begin
      rd_word[24:0] = st.ddr;
    end else if (i_paddr == `PSR_OFF_PORT) begin
      rd_word[23:0] = st.port_out;
    end else if (i_paddr == `PSR_OFF_STATUS) begin
      rd_word[0] = init_low;
      rd_word[1] = i_wdt_reset;
      rd_word[4:2] = st.bus_state;
      rd_word[5] = i_sw_standby;
      rd_word[6] = i_hw_standby;
    end else begin
      hit = 1'b0;
    end
    next_st.pready  = i_psel & i_penable & ~st.pready;
    next_st.pslverr = next_st.pready & ~hit;
    next_st.prdata  = (next_st.pready & ~i_pwrite) ? rd_word :
                      32'h0000_0000;
    // Writes to the status word or to an unmapped offset change nothing.
    if (apb_wr & hit) begin
      if (i_paddr == `PSR_OFF_CTRL) begin
        next_st.mode = i_pwdata[`PSR_CTRL_MODE_HI:`PSR_CTRL_MODE_LO];
        next_st.adrc = i_pwdata[`PSR_CTRL_ADRC];
      end else if (i_paddr == `PSR_OFF_DDR) begin
        next_st.ddr = i_pwdata[24:0];
      end else if (i_paddr == `PSR_OFF_PORT) begin
        next_st.port_out = i_pwdata[23:0];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.mode <= 3'(`PSR_CTRL_RST);
      st.ddr <= `PSR_DDR_RST;
      st.port_out <= `PSR_PORT_RST;
      st.clk_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge i_clock or posedge pin_rst) begin
    if (pin_rst) begin
      pn <= '0;
      pn.as_n <= 1'b1;
      pn.rd_n <= 1'b1;
      pn.wr_n <= 1'b1;
      pn.strobe_oe <= 1'b1;
    end else begin
      pn <= next_pn;
    end
  end

  assign o_pready        = st.pready;
  assign o_pslverr       = st.pslverr;
  assign o_prdata        = st.prdata;
  assign o_acc_done      = st.acc_done;
  assign o_acc_rdata     = st.acc_rdata;
  assign o_addr          = st.addr;
  assign o_addr_oe       = st.addr_oe;
  assign o_data          = pn.data;
  assign o_data_oe       = pn.data_oe;
  assign o_addr_strobe_n = pn.as_n;
  assign o_rd_n          = pn.rd_n;
  assign o_wr_n          = pn.wr_n;
  assign o_strobe_oe     = pn.strobe_oe;
  assign o_cs            = pn.cs_oe;
  assign o_cs_oe         = pn.cs_oe;
  // The reset output is open drain: only its enable ever changes.
  assign o_reset_out_n   = 1'b0;
  assign o_reset_out_oe  = st.rst_out_oe;
  assign o_clk_out       = st.clk_out;
  assign o_clk_oe        = st.clk_oe;
endmodule

// [tb/psr_checker.sv]
`timescale 1ns/100ps
module psr_checker (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_chip_init_n,
  input wire logic        i_hw_standby,
  input wire logic        i_sw_standby,
  input wire logic        i_wdt_reset,
  input wire logic [23:0] o_addr_oe,
  input wire logic        o_data_oe,
  input wire logic        o_addr_strobe_n,
  input wire logic        o_rd_n,
  input wire logic        o_wr_n,
  input wire logic        o_strobe_oe,
  input wire logic        o_cs,
  input wire logic        o_cs_oe,
  input wire logic        o_reset_out_oe,
  input wire logic        o_clk_out,
  input wire logic        o_clk_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_strobe_high: assert property (!i_chip_init_n |->
    o_addr_strobe_n && o_rd_n && o_wr_n && o_strobe_oe)
    else $error("strobe active during chip reset");
  a_data_float: assert property (!i_chip_init_n |-> !o_data_oe)
    else $error("data bus driven during chip reset");
  a_pins_input: assert property (!i_chip_init_n |-> !o_cs_oe)
    else $error("port pin driven during chip reset");
  a_hw_float: assert property (i_hw_standby [*2] |->
    o_addr_oe == 24'h0 && !o_data_oe && !o_cs_oe && !o_reset_out_oe
    && !o_clk_oe) else $error("pin driven in hardware standby");
  a_wdt_low: assert property ((i_wdt_reset && !i_hw_standby) [*2] |->
    o_reset_out_oe) else $error("reset output not low on watchdog");
  a_reset_float: assert property ((!i_wdt_reset) [*2] |->
    !o_reset_out_oe) else $error("reset output driven without watchdog");
  a_select_high: assert property (
    o_cs_oe |-> o_cs && !$past(i_hw_standby))
    else $error("select pin driven low or in hardware standby");
  a_clock_runs: assert property ((!i_hw_standby) [*3] |->
    o_clk_oe && o_clk_out != $past(o_clk_out))
    else $error("clock output stalled");
  a_standby_keep: assert property (
    (i_sw_standby && i_chip_init_n && !i_hw_standby) [*3] |->
    $stable(o_addr_oe) && $stable(o_cs_oe))
    else $error("pin state moved in software standby");
  c_chip_reset: cover property (!i_chip_init_n && o_addr_oe != 24'h0);
  c_watchdog: cover property (o_reset_out_oe);
  c_standby: cover property (i_sw_standby && o_cs);
endmodule
bind psr_top psr_checker u_chk (.i_clock, .i_rst, .i_chip_init_n,
  .i_hw_standby, .i_sw_standby, .i_wdt_reset, .o_addr_oe, .o_data_oe,
  .o_addr_strobe_n, .o_rd_n, .o_wr_n, .o_strobe_oe, .o_cs, .o_cs_oe,
  .o_reset_out_oe, .o_clk_out, .o_clk_oe);

// [tb/psr_mem_model.sv]
`timescale 1ns/100ps
module psr_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_slow,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_oe,
  input  wire logic [23:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wdata_oe,
  output logic      [7:0]  o_rdata,
  output logic             o_wait_n,
  output logic      [7:0]  o_last_wr
);
  int         cnt = 0;
  logic [7:0] last = 8'h00;
  always @(posedge i_clock) begin
    cnt <= (i_rd_n && i_wr_n) ? 0 : cnt + 1;
    last <= o_rdata;
    if (!i_wr_n && i_wdata_oe) begin
      o_last_wr <= i_wdata;
    end
  end
  // A released bus flips every cycle so a stale value can never match.
  assign o_rdata = (!i_rd_n && i_oe) ? (i_addr[7:0] ^ 8'h5a) : ~last;
  assign o_wait_n = !(i_slow && cnt < 3);
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
`include "psr_defines.svh"
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module testbench;
  logic i_clock = 0, i_rst = 1, i_chip_init_n = 1, i_hw_standby = 0;
  logic i_sw_standby = 0, i_wdt_reset = 0, i_acc_start = 0, slow = 0;
  logic i_acc_write = 0, i_acc_two_state = 0, i_wait_n, i_psel = 0;
  logic i_penable = 0, i_pwrite = 0, o_pready, o_pslverr, o_acc_done;
  logic o_data_oe, o_addr_strobe_n, o_rd_n, o_wr_n, o_strobe_oe, o_cs;
  logic o_cs_oe, o_reset_out_n, o_reset_out_oe, o_clk_out, o_clk_oe, err;
  logic [7:0]  i_paddr = 0, i_acc_wdata = 0, i_data, o_acc_rdata;
  logic [7:0]  o_data, wr, e;
  logic [23:0] i_acc_addr = 0, o_addr, o_addr_oe;
  logic [31:0] i_pwdata = 0, o_prdata, rd, seed = 75;
  int          fail_count = 0, num_checks = 0, cyc = 0;
  logic [7:0]  expq[$];
  always #20 i_clock = ~i_clock;
  psr_top DUT (.i_clock, .i_rst, .i_chip_init_n, .i_hw_standby,
    .i_sw_standby, .i_wdt_reset, .i_acc_start, .i_acc_write,
    .i_acc_two_state, .i_acc_addr, .i_acc_wdata, .i_wait_n, .i_data,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
    .o_pslverr, .o_prdata, .o_acc_done, .o_acc_rdata, .o_addr, .o_addr_oe,
    .o_data, .o_data_oe, .o_addr_strobe_n, .o_rd_n, .o_wr_n, .o_strobe_oe,
    .o_cs, .o_cs_oe, .o_reset_out_n, .o_reset_out_oe, .o_clk_out,
    .o_clk_oe);
  psr_mem_model mem (.i_clock, .i_slow(slow), .i_rd_n(o_rd_n),
    .i_wr_n(o_wr_n), .i_oe(o_strobe_oe), .i_addr(o_addr), .i_wdata(o_data),
    .i_wdata_oe(o_data_oe), .o_rdata(i_data), .o_wait_n(i_wait_n),
    .o_last_wr(wr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge i_clock) if (++cyc == 6000) begin
    fail_count++;
    finish_test();
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel <= 1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic start(input logic w, two, s, input logic [31:0] r);
    @(posedge i_clock);
    slow <= s;
    i_acc_start <= 1;
    i_acc_write <= w;
    i_acc_two_state <= two;
    i_acc_addr <= r[23:0];
    i_acc_wdata <= r[31:24];
    @(posedge i_clock);
    i_acc_start <= 0;
  endtask
  task automatic acc(input logic w, two, s);
    logic [31:0] r;
    r = rnd();
    if (!w) expq.push_back(r[7:0] ^ 8'h5a);
    start(w, two, s, r);
    do @(negedge i_clock); while (o_acc_done !== 1);
    e = w ? r[31:24] : expq.pop_front();
    `CHK("access data", e, w ? wr : o_acc_rdata)
  endtask
  task automatic rs(input logic two, s, input int k, input logic held);
    logic [31:0] r;
    logic [23:0] ea;
    r = rnd();
    ea = held ? {4'h0, r[19:0]} : 24'h0;
    apb(1, `PSR_OFF_CTRL, 32'h1);
    start(0, two, s, r);
    repeat (k - 1) @(posedge i_clock);
    i_chip_init_n <= 0;
    #1;
    `CHK("strobes", 3'h7, ({o_addr_strobe_n, o_rd_n, o_wr_n}))
    `CHK("strobe oe", 1'b1, o_strobe_oe)
    `CHK("data and select oe", 2'b00, ({o_data_oe, o_cs_oe}))
    @(posedge i_clock);
    #1;
    `CHK("addr after sample", ea, o_addr)
    @(posedge i_clock);
    #1;
    `CHK("addr low", 24'h0, o_addr)
    `CHK("addr oe", 20'hfffff, o_addr_oe[19:0])
    @(posedge i_clock);
    i_chip_init_n <= 1;
    slow <= 0;
    repeat (3) @(posedge i_clock);
  endtask
  task automatic standby(input logic [23:0] m, run, sb, input int t);
    repeat (2) @(negedge i_clock);
    `CHK("running oe", run, o_addr_oe & m)
    @(posedge i_clock);
    i_sw_standby <= 1;
    repeat (4) @(negedge i_clock);
    `CHK("standby oe", sb, o_addr_oe & m)
    if (t) `CHK("select", 2'b11, ({o_cs, o_cs_oe}))
    @(posedge i_clock);
    i_sw_standby <= 0;
  endtask
  initial begin
    repeat (12) @(posedge i_clock);
    i_rst <= 0;
    apb(0, `PSR_OFF_CTRL, 0);
    `CHK("ctrl reset", 32'h1, rd)
    apb(0, 8'h10, 0);
    `CHK("unmapped", 1'b1, err)
    apb(1, `PSR_OFF_DDR, 32'h01ff_ffff);
    for (int i = 0; i < 8; i++) acc(i[0], i[1], i[2]);
    $display("test access done");
    rs(0, 0, 1, 0);
    rs(0, 0, 2, 0);
    rs(0, 1, 3, 0);
    rs(0, 0, 3, 1);
    rs(1, 0, 2, 1);
    $display("test chip reset done");
    apb(1, `PSR_OFF_CTRL, 32'h5);
    apb(1, `PSR_OFF_DDR, 32'h0100_000f);
    standby(24'h0000ff, 24'h00000f, 24'h0, 1);
    apb(1, `PSR_OFF_CTRL, 32'h3);
    standby(24'he00000, 24'he00000, 24'h0, 0);
    apb(1, `PSR_OFF_CTRL, 32'hb);
    apb(1, `PSR_OFF_DDR, 32'h01e0_000f);
    standby(24'he00000, 24'he00000, 24'he00000, 0);
    i_hw_standby <= 1;
    repeat (3) @(negedge i_clock);
    `CHK("hw addr oe", 24'h0, o_addr_oe)
    `CHK("hw clock oe", 2'h0, ({o_clk_oe, o_reset_out_oe}))
    `CHK("hw pin oe", 3'h0, ({o_strobe_oe, o_cs_oe, o_data_oe}))
    @(posedge i_clock);
    i_hw_standby <= 0;
    i_wdt_reset <= 1;
    repeat (3) @(negedge i_clock);
    `CHK("watchdog out", 2'b10, ({o_reset_out_oe, o_reset_out_n}))
    @(posedge i_clock);
    i_wdt_reset <= 0;
    apb(1, `PSR_OFF_DDR, 32'h0);
    repeat (2) @(negedge i_clock);
    `CHK("select input", 1'b0, o_cs_oe)
    $display("test standby done");
    finish_test();
  end
endmodule
